// >>> hdl/msc_comp.sv
// magnetic signal compensation: gain and offset stages with register port
`timescale 1ns/100ps
`default_nettype none
module msc_comp
  import msc_pkg::*;
#(
  parameter int SAMPLE_W  = 16, // digitizer sample width
  parameter int BASE_GAIN = 1   // digital base gain
) (
  input  wire logic                        clock_i,                  // 200 MHz clock
  input  wire logic                        arst_n_i,                 // async reset, low
  input  wire logic [7:0]                  reg_addr_i,               // register index
  input  wire logic [31:0]                 reg_wdata_i,              // write data
  input  wire logic                        reg_wr_i,                 // write strobe
  input  wire logic                        reg_rd_i,                 // read strobe
  output logic      [31:0]                 reg_rdata_o,              // read data, next cycle
  input  wire logic signed [SAMPLE_W-1:0]  sample_i,                 // digitized field
  input  wire logic                        sample_valid_i,           // sample strobe
  input  wire logic signed [8:0]           ambient_temp_i,           // ambient, whole deg C
  output logic signed [msc_pkg::Y2_W-1:0]  comp_data_o,              // compensated value
  output logic                             comp_valid_o,             // result strobe
  output logic [msc_pkg::LIM_W-1:0]        low_output_limit_o,       // low limit code
  output logic [msc_pkg::LIM_W-1:0]        high_output_limit_o,      // high limit code
  output logic [msc_pkg::PS_W-1:0]         post_shape_gain_trim_o,   // post-shaper gain
  output logic [msc_pkg::PS_W-1:0]         post_shape_offset_trim_o, // post-shaper offset
  output logic                             shaper_input_invert_o,    // shaper input polarity
  output logic                             shaper_output_invert_o    // shaper output polarity
);
  localparam int PROD_W = 72;
  localparam int SUM_W  = 28;

  initial begin
    if (SAMPLE_W < 8 || SAMPLE_W > 24) $error("msc_comp: SAMPLE_W out of range");
    if (BASE_GAIN < 1 || BASE_GAIN > 15) $error("msc_comp: BASE_GAIN out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic                     pol_reg;
  logic [COARSE_W-1:0]      coarse_reg;
  logic [FINE_W-1:0]        fine_reg;
  logic signed [TC1_W-1:0]  tc1_hot_reg;
  logic signed [TC1_W-1:0]  tc1_cld_reg;
  logic signed [TC2_W-1:0]  tc2_hot_reg;
  logic signed [TC2_W-1:0]  tc2_cld_reg;
  logic signed [QO_W-1:0]   qo_reg;
  logic signed [QOTC_W-1:0] qotc_hot_reg;
  logic signed [QOTC_W-1:0] qotc_cld_reg;
  logic [LIM_W-1:0]         low_lim_reg;
  logic [LIM_W-1:0]         high_lim_reg;
  logic [PS_W-1:0]          ps_gain_reg;
  logic [PS_W-1:0]          ps_ofs_reg;
  logic                     in_inv_reg;
  logic                     out_inv_reg;
  logic [31:0]              rdata_reg;
  logic [31:0]              rdata_next;

  // gain trim word: polarity, coarse, fine
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pol_reg    <= 1'b0;
      coarse_reg <= '0;
      fine_reg   <= FINE_RST;
    end else if (reg_wr_i && reg_addr_i == SENS_TRIM_ADDR) begin
      pol_reg    <= reg_wdata_i[POL_BIT];
      coarse_reg <= reg_wdata_i[COARSE_LSB +: COARSE_W];
      fine_reg   <= reg_wdata_i[FINE_W-1:0];
    end
  end

  // gain temperature coefficients
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tc1_hot_reg <= '0;
      tc1_cld_reg <= '0;
      tc2_hot_reg <= '0;
      tc2_cld_reg <= '0;
    end else if (reg_wr_i && reg_addr_i == LIN_TC_ADDR) begin
      tc1_hot_reg <= reg_wdata_i[TC1_W-1:0];
      tc1_cld_reg <= reg_wdata_i[COLD_LSB +: TC1_W];
    end else if (reg_wr_i && reg_addr_i == SQ_TC_ADDR) begin
      tc2_hot_reg <= reg_wdata_i[TC2_W-1:0];
      tc2_cld_reg <= reg_wdata_i[COLD_LSB +: TC2_W];
    end
  end

  // offset trims
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      qo_reg       <= '0;
      qotc_hot_reg <= '0;
      qotc_cld_reg <= '0;
    end else if (reg_wr_i && reg_addr_i == QO_ADDR) begin
      qo_reg <= reg_wdata_i[QO_W-1:0];
    end else if (reg_wr_i && reg_addr_i == QOTC_ADDR) begin
      qotc_hot_reg <= reg_wdata_i[QOTC_W-1:0];
      qotc_cld_reg <= reg_wdata_i[COLD_LSB +: QOTC_W];
    end
  end

  // limits and post-shaper settings, passed straight out
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_lim_reg  <= '0;
      high_lim_reg <= HIGH_LIM_RST;
      ps_gain_reg  <= '0;
      ps_ofs_reg   <= '0;
      in_inv_reg   <= 1'b0;
      out_inv_reg  <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == LIMIT_ADDR) begin
      low_lim_reg  <= reg_wdata_i[LIM_W-1:0];
      high_lim_reg <= reg_wdata_i[HIGH_LIM_LSB +: LIM_W];
    end else if (reg_wr_i && reg_addr_i == SHAPE_ADDR) begin
      ps_gain_reg <= reg_wdata_i[PS_W-1:0];
      ps_ofs_reg  <= reg_wdata_i[PS_OFS_LSB +: PS_W];
      in_inv_reg  <= reg_wdata_i[IN_INV_BIT];
      out_inv_reg <= reg_wdata_i[OUT_INV_BIT];
    end
  end

  assign low_output_limit_o       = low_lim_reg;
  assign high_output_limit_o      = high_lim_reg;
  assign post_shape_gain_trim_o   = ps_gain_reg;
  assign post_shape_offset_trim_o = ps_ofs_reg;
  assign shaper_input_invert_o    = in_inv_reg;
  assign shaper_output_invert_o   = out_inv_reg;

  ////////////////////////////////////////////////////////////////////////////
  // gain stage
  logic signed [DT_W-1:0]   dt_w;
  logic                     hot_w;
  logic signed [FACT_W-1:0] factor_w;
  logic signed [SAMPLE_W:0] signed_sample_w;
  logic [9:0]               gain_w;
  logic [11:0]              fine_w;
  logic signed [PROD_W-1:0] prod_w;
  logic signed [Y1_W-1:0]   y1_sat_w;
  logic                     y1_clip_w;
  logic signed [Y1_W-1:0]   y1_reg;
  logic signed [DT_W-1:0]   dt_reg;
  logic                     hot_reg;
  logic                     s1_valid_reg;

  assign dt_w  = DT_W'(ambient_temp_i) - DT_W'(REF_TEMP);
  assign hot_w = !dt_w[DT_W-1];
  assign signed_sample_w = pol_reg ? -(SAMPLE_W+1)'(sample_i)
                                   : (SAMPLE_W+1)'(sample_i);
  assign gain_w = 10'(BASE_GAIN) * 10'(msc_coarse_mult(coarse_reg));
  assign fine_w = FINE_BASE + 12'(fine_reg);
  assign prod_w = (PROD_W'(signed_sample_w) * PROD_W'($signed({1'b0, gain_w}))
                 * PROD_W'($signed({1'b0, fine_w})) * PROD_W'(factor_w))
                 >>> (FINE_SHIFT + FRAC_W);

  msc_tc_factor u_factor (
    .dt_i      (dt_w),
    .hot_i     (hot_w),
    .tc1_hot_i (tc1_hot_reg),
    .tc1_cld_i (tc1_cld_reg),
    .tc2_hot_i (tc2_hot_reg),
    .tc2_cld_i (tc2_cld_reg),
    .factor_o  (factor_w)
  );

  msc_sat #(.IN_W(PROD_W), .OUT_W(Y1_W)) u_sat_gain (
    .in_i  (prod_w),
    .out_o (y1_sat_w),
    .sat_o (y1_clip_w)
  );

  // first pipeline stage keeps the delta it used so both stages agree
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      y1_reg       <= '0;
      dt_reg       <= '0;
      hot_reg      <= 1'b0;
      s1_valid_reg <= 1'b0;
    end else begin
      s1_valid_reg <= sample_valid_i;
      if (sample_valid_i) begin
        y1_reg  <= y1_sat_w;
        dt_reg  <= dt_w;
        hot_reg <= hot_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // offset stage, sums carried in 1/64 lsb
  logic signed [SUM_W-1:0] ofs_sum_w;
  logic signed [SUM_W-1:0] drift_w;
  logic signed [Y2_W-1:0]  y2_sat_w;
  logic                    y2_clip_w;
  logic signed [Y2_W-1:0]  y2_reg;
  logic                    s2_valid_reg;

  // cold offset coefficient lsb is twice the hot one
  assign drift_w = hot_reg ? SUM_W'(qotc_hot_reg) * SUM_W'(dt_reg)
                           : (SUM_W'(qotc_cld_reg) * SUM_W'(dt_reg)) <<< 1;
  assign ofs_sum_w = ((SUM_W'(y1_reg) + SUM_W'(qo_reg)) <<< QOTC_FRAC) + drift_w;

  msc_sat #(.IN_W(SUM_W - QOTC_FRAC), .OUT_W(Y2_W)) u_sat_ofs (
    .in_i  (ofs_sum_w[SUM_W-1:QOTC_FRAC]),
    .out_o (y2_sat_w),
    .sat_o (y2_clip_w)
  );

  // second pipeline stage drives the block output
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      y2_reg       <= '0;
      s2_valid_reg <= 1'b0;
    end else begin
      s2_valid_reg <= s1_valid_reg;
      if (s1_valid_reg) begin
        y2_reg <= y2_sat_w;
      end
    end
  end

  assign comp_data_o  = y2_reg;
  assign comp_valid_o = s2_valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data valid only in the cycle after the strobe
  always_comb begin
    rdata_next = '0;
    case (reg_addr_i)
      SENS_TRIM_ADDR: rdata_next = 32'({pol_reg, coarse_reg, 1'b0, fine_reg});
      LIN_TC_ADDR:    rdata_next = 32'({tc1_cld_reg, 1'b0, tc1_hot_reg});
      SQ_TC_ADDR:     rdata_next = 32'({tc2_cld_reg, 2'b00, tc2_hot_reg});
      QO_ADDR:        rdata_next = 32'({qo_reg});
      QOTC_ADDR:      rdata_next = 32'({qotc_cld_reg, qotc_hot_reg});
      LIMIT_ADDR:     rdata_next = 32'({high_lim_reg, low_lim_reg});
      SHAPE_ADDR:     rdata_next = 32'({out_inv_reg, in_inv_reg, ps_ofs_reg, ps_gain_reg});
      RESULT_ADDR:    rdata_next = 32'({y2_clip_w, 18'h0_0000, y2_reg});
      GAIN_RES_ADDR:  rdata_next = 32'({y1_clip_w, 14'h0000, y1_reg});
      default:        rdata_next = '0;
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= reg_rd_i ? rdata_next : 32'h0000_0000;
    end
  end

  assign reg_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  pipe_latency_a: assert property (sample_valid_i |-> !comp_valid_o ##2 comp_valid_o or ##2 comp_valid_o)
    else $error("result strobe not two cycles after sample");
  hot_select_a: assert property (sample_valid_i && ambient_temp_i > 9'sd25 |=> hot_reg)
    else $error("hot set not chosen above reference");
  cold_select_a: assert property (sample_valid_i && ambient_temp_i < 9'sd25 |=> !hot_reg)
    else $error("cold set not chosen below reference");
  unity_factor_a: assert property (ambient_temp_i == 9'sd25 |-> factor_w == (FACT_W'(1) <<< FRAC_W))
    else $error("correction not unity at reference");
  gain_sat_hi_a: assert property (sample_valid_i && y1_clip_w && !prod_w[PROD_W-1]
                                  |=> y1_reg == 17'sh0_ffff)
    else $error("gain stage did not clip high");
  ofs_sat_lo_a: assert property (s1_valid_reg && y2_clip_w && ofs_sum_w[SUM_W-1]
                                 |=> comp_data_o == 13'sh1000)
    else $error("offset stage did not clip low");
  zero_path_a: assert property (sample_valid_i && sample_i == '0 && ambient_temp_i == 9'sd25
                                && !(reg_wr_i && reg_addr_i == QO_ADDR) && qo_reg > -16'sd4096
                                && qo_reg < 16'sd4096 |-> ##2 comp_data_o == Y2_W'($past(qo_reg, 2)))
    else $error("zero input does not give quiescent trim");
  trim_readback_a: assert property (reg_wr_i && reg_addr_i == QO_ADDR ##1 reg_rd_i && reg_addr_i == QO_ADDR
                                    |=> reg_rdata_o[15:0] == $past(reg_wdata_i[15:0], 2))
    else $error("quiescent trim readback mismatch");
  polarity_a: assert property (sample_valid_i && sample_i > 0 && !y1_clip_w && pol_reg
                               |=> y1_reg <= 0)
    else $error("inverted polarity kept sign");

  hot_cover_c:  cover property (sample_valid_i && ambient_temp_i > 9'sd25 ##2 comp_valid_o);
  cold_cover_c: cover property (sample_valid_i && ambient_temp_i < 9'sd25 ##2 comp_valid_o);
  clip_cover_c: cover property (s1_valid_reg && y2_clip_w);
  read_cover_c: cover property (reg_rd_i && reg_addr_i == RESULT_ADDR);
endmodule
`default_nettype wire

// >>> hdl/msc_pkg.sv
// package: register map, field layout, widths and scaling of the compensation block
package msc_pkg;
  // register indices on the plain register port
  localparam logic [7:0] SENS_TRIM_ADDR = 8'h03;
  localparam logic [7:0] LIN_TC_ADDR    = 8'h04;
  localparam logic [7:0] SQ_TC_ADDR     = 8'h05;
  localparam logic [7:0] QO_ADDR        = 8'h06;
  localparam logic [7:0] QOTC_ADDR      = 8'h07;
  localparam logic [7:0] LIMIT_ADDR     = 8'h08;
  localparam logic [7:0] SHAPE_ADDR     = 8'h09;
  localparam logic [7:0] RESULT_ADDR    = 8'h0a;
  localparam logic [7:0] GAIN_RES_ADDR  = 8'h0b;
  // field positions
  localparam int POL_BIT      = 15;
  localparam int COARSE_LSB   = 12;
  localparam int COLD_LSB     = 12;
  localparam int HIGH_LIM_LSB = 12;
  localparam int PS_OFS_LSB   = 12;
  localparam int IN_INV_BIT   = 24;
  localparam int OUT_INV_BIT  = 25;
  // field widths
  localparam int COARSE_W = 3;
  localparam int FINE_W   = 11;
  localparam int TC1_W    = 11;
  localparam int TC2_W    = 10;
  localparam int QO_W     = 16;
  localparam int QOTC_W   = 12;
  localparam int LIM_W    = 12;
  localparam int PS_W     = 12;
  localparam int Y1_W     = 17;
  localparam int Y2_W     = 13;
  localparam int DT_W     = 10;
  localparam int FACT_W   = 34;
  // reset values
  localparam logic [FINE_W-1:0] FINE_RST     = 11'h400;
  localparam logic [LIM_W-1:0]  HIGH_LIM_RST = 12'hfff;
  // scaling: gain correction in units of 2^-26, fine code is (1024+code)/2048
  localparam int          FRAC_W      = 26;
  localparam int          FINE_SHIFT  = 11;
  localparam logic [11:0] FINE_BASE   = 12'h400;
  localparam int          TC1_HOT_SH  = 8;
  localparam int          TC1_COLD_SH = 9;
  localparam int          TC2_HOT_SH  = 1;
  localparam int          TC2_COLD_SH = 3;
  localparam int          QOTC_FRAC   = 6;
  localparam int          REF_TEMP    = 25;

  // coarse code to multiplier, 1 up to 32
  function automatic logic [5:0] msc_coarse_mult(input logic [COARSE_W-1:0] code);
    case (code)
      3'h0:    msc_coarse_mult = 6'h01;
      3'h1:    msc_coarse_mult = 6'h02;
      3'h2:    msc_coarse_mult = 6'h03;
      3'h3:    msc_coarse_mult = 6'h04;
      3'h4:    msc_coarse_mult = 6'h06;
      3'h5:    msc_coarse_mult = 6'h08;
      3'h6:    msc_coarse_mult = 6'h10;
      default: msc_coarse_mult = 6'h20;
    endcase
  endfunction
endpackage

// >>> hdl/msc_sat.sv
// signed saturating resize
`timescale 1ns/100ps
`default_nettype none
module msc_sat #(
  parameter int IN_W  = 32,
  parameter int OUT_W = 16
) (
  input  wire logic signed [IN_W-1:0]  in_i,  // wide value
  output logic signed      [OUT_W-1:0] out_o, // clipped value
  output logic                         sat_o  // clipping took place
);
  initial begin
    if (OUT_W < 2 || IN_W <= OUT_W) $error("msc_sat: bad widths");
  end

  // upper bits must all copy the sign, else clip to the nearer end
  always_comb begin
    sat_o = !((&in_i[IN_W-1:OUT_W-1]) || !(|in_i[IN_W-1:OUT_W-1]));
    if (!sat_o) begin
      out_o = in_i[OUT_W-1:0];
    end else if (in_i[IN_W-1]) begin
      out_o = {1'b1, {(OUT_W-1){1'b0}}};
    end else begin
      out_o = {1'b0, {(OUT_W-1){1'b1}}};
    end
  end
endmodule
`default_nettype wire

// >>> hdl/msc_tc_factor.sv
// temperature gain correction factor, 1.0 = 2^26
`timescale 1ns/100ps
`default_nettype none
module msc_tc_factor
  import msc_pkg::*;
(
  input  wire logic signed [msc_pkg::DT_W-1:0]  dt_i,      // ambient minus reference
  input  wire logic                             hot_i,     // hot set selected
  input  wire logic signed [msc_pkg::TC1_W-1:0] tc1_hot_i, // hot linear coefficient
  input  wire logic signed [msc_pkg::TC1_W-1:0] tc1_cld_i, // cold linear coefficient
  input  wire logic signed [msc_pkg::TC2_W-1:0] tc2_hot_i, // hot square coefficient
  input  wire logic signed [msc_pkg::TC2_W-1:0] tc2_cld_i, // cold square coefficient
  output logic signed      [msc_pkg::FACT_W-1:0] factor_o // correction factor
);
  logic signed [FACT_W-1:0] dt_sq;
  logic signed [FACT_W-1:0] lin_term;
  logic signed [FACT_W-1:0] sq_term;

  // 1 + (tc2/1000*dT + tc1)*dT/100, scaled to fixed point; cold lsb is coarser
  always_comb begin
    dt_sq = FACT_W'(dt_i) * FACT_W'(dt_i);
    if (hot_i) begin
      lin_term = (FACT_W'(tc1_hot_i) * FACT_W'(dt_i)) <<< TC1_HOT_SH;
      sq_term  = (FACT_W'(tc2_hot_i) * dt_sq) <<< TC2_HOT_SH;
    end else begin
      lin_term = (FACT_W'(tc1_cld_i) * FACT_W'(dt_i)) <<< TC1_COLD_SH;
      sq_term  = (FACT_W'(tc2_cld_i) * dt_sq) <<< TC2_COLD_SH;
    end
    factor_o = (FACT_W'(1) <<< FRAC_W) + lin_term + sq_term;
  end
endmodule
`default_nettype wire

// >>> verif/msc_comp_tb.sv
// testbench: register port and compensation datapath of msc_comp
`timescale 1ns/100ps
`default_nettype none
module msc_comp_tb;
  import msc_pkg::*;
  logic               clock = 1'b0;
  logic               arst_n = 1'b0;
  logic [7:0]         addr = '0;
  logic [31:0]        wdata = '0;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic [31:0]        rdata;
  logic signed [15:0] sample;
  logic               valid;
  logic signed [8:0]  temp;
  logic signed [12:0] comp_data;
  logic               comp_valid;
  logic [11:0]        low_lim, high_lim, ps_gain, ps_ofs;
  logic               in_inv, out_inv;
  int                 fails = 0;
  int                 samples_checked = 0;
  int                 mt[8] = '{1, 2, 3, 4, 6, 8, 16, 32};
  logic [7:0]         ra[7] = '{SENS_TRIM_ADDR, LIN_TC_ADDR, SQ_TC_ADDR, QO_ADDR, QOTC_ADDR, LIMIT_ADDR, SHAPE_ADDR};
  logic [31:0]        rm[7] = '{32'h0000_f7ff, 32'h007f_f7ff, 32'h003f_f3ff, 32'h0000_ffff, 32'h00ff_ffff,
                                32'h00ff_ffff, 32'h03ff_ffff};
  logic [31:0]        rr[7] = '{32'h0000_0400, 0, 0, 0, 0, 32'h00ff_f000, 0};

  // 200 MHz clock
  always #2.5 clock = ~clock;

  msc_comp i_msc_comp (
    .clock_i(clock), .arst_n_i(arst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .sample_i(sample), .sample_valid_i(valid),
    .ambient_temp_i(temp), .comp_data_o(comp_data), .comp_valid_o(comp_valid),
    .low_output_limit_o(low_lim), .high_output_limit_o(high_lim), .post_shape_gain_trim_o(ps_gain),
    .post_shape_offset_trim_o(ps_ofs), .shaper_input_invert_o(in_inv), .shaper_output_invert_o(out_inv)
  );
  msc_hall_model i_msc_hall_model (
    .clock_i(clock), .sample_o(sample), .sample_valid_o(valid), .ambient_temp_o(temp)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // compare, verdict and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr    <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd   <= 1'b0;
    @(negedge clock);
    chk(rdata, exp);
  endtask
  // write, then read the same index in the very next cycle
  task automatic wrrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge clock);
    rd    <= 1'b0;
    @(negedge clock);
    chk(rdata, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reference arithmetic in fixed point
  function automatic longint clip(input longint y, input longint lim);
    return (y > lim) ? lim : ((y < -lim - 1) ? -lim - 1 : y);
  endfunction
  function automatic logic [31:0] y2e(input int p, c, f, a, b, g, h, q, u, v, s, t);
    longint d, fa, y;
    d  = t - 25;
    fa = (longint'(1) << 26) + ((t >= 25) ? a * d * 256 + g * d * d * 2 : b * d * 512 + h * d * d * 8);
    y  = (longint'(s) * (p ? -1 : 1) * mt[c] * (1024 + f) * fa) >>> 37;
    y  = clip(y, 65535);
    y  = ((y + q) * 64 + ((t >= 25) ? u * d : v * d * 2)) >>> 6;
    return 32'(clip(y, 4095)) & 32'h0000_1fff;
  endfunction
  // program the trims, push one sample, compare the result
  task automatic run(input int p, c, f, a, b, g, h, q, u, v, s, t);
    int n;
    wreg(SENS_TRIM_ADDR, 32'((p << 15) | (c << 12) | f));
    wreg(LIN_TC_ADDR, 32'(((b & 'h7ff) << 12) | (a & 'h7ff)));
    wreg(SQ_TC_ADDR, 32'(((h & 'h3ff) << 12) | (g & 'h3ff)));
    wreg(QO_ADDR, 32'(q & 'hffff));
    wreg(QOTC_ADDR, 32'(((v & 'hfff) << 12) | (u & 'hfff)));
    i_msc_hall_model.send(s, t);
    n = 0;
    while (comp_valid !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    if (n >= 8) begin
      fails++;
      end_of_test();
    end else begin
      chk({19'h0_0000, comp_data}, y2e(p, c, f, a, b, g, h, q, u, v, s, t));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    chk({8'h00, high_lim, low_lim}, 32'h00ff_f000);
    for (int i = 0; i < 7; i++) begin
      rreg(ra[i], rr[i]);
      wreg(ra[i], 32'hffff_ffff);
      rreg(ra[i], rm[i]);
    end
    wreg(8'h20, 32'hffff_ffff);
    rreg(8'h20, 32'h0000_0000);
    wrrd(QO_ADDR, 32'h0000_8a5c, 32'h0000_8a5c);
    wreg(LIMIT_ADDR, 32'h00ab_c123);
    wreg(SHAPE_ADDR, 32'h025a_63c9);
    @(posedge clock);
    chk({8'h00, high_lim, low_lim}, 32'h00ab_c123);
    chk({6'h00, out_inv, in_inv, ps_ofs, ps_gain}, 32'h025a_63c9);
    wreg(SHAPE_ADDR, 32'h0100_0000);
    @(posedge clock);
    chk({6'h00, out_inv, in_inv, ps_ofs, ps_gain}, 32'h0100_0000);
    for (int c = 0; c < 8; c++) begin
      run(0, c, 0, 0, 0, 0, 0, 0, 0, 0, 1000, 25);
    end
    run(0, 7, 2047, 0, 0, 0, 0, 0, 0, 0, -2000, 25);
    rreg(RESULT_ADDR, 32'h8000_1000);
    run(0, 7, 2047, 0, 0, 0, 0, 0, 0, 0, 2000, 25);
    run(0, 0, 1024, 0, 0, 0, 0, 0, 0, 0, 100, 25);
    rreg(GAIN_RES_ADDR, 32'h0000_0064);
    run(1, 2, 1024, 0, 0, 0, 0, 0, 0, 0, 300, 25);
    run(1, 0, 1024, 100, -300, 50, -20, 200, 64, -32, 1000, 85);
    run(1, 0, 1024, 100, -300, 50, -20, 200, 64, -32, 1000, -15);
    run(0, 0, 1024, 100, -300, 50, -20, 200, 64, -32, 1000, 25);
    run(0, 0, 1024, 0, 0, 0, 0, -32768, 0, 0, 0, 25);
    run(0, 0, 1024, 0, 0, 0, 0, -1234, 0, 0, 0, 25);
    run(0, 0, 1024, 0, 0, 0, 0, 3000, -2048, 2047, 0, 125);
    run(0, 0, 1024, 0, 0, 0, 0, 3000, -2048, 2047, 0, -25);
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> verif/msc_hall_model.sv
// partner model: digitized transducer sample and ambient temperature source
`timescale 1ns/100ps
`default_nettype none
module msc_hall_model #(
  parameter int SAMPLE_W = 16 // sample width
) (
  input  wire logic                   clock_i,        // block clock
  output logic signed [SAMPLE_W-1:0] sample_o,       // digitized field
  output logic                        sample_valid_o, // sample strobe
  output logic signed [8:0]           ambient_temp_o  // ambient, deg C
);
  // idle values before the first conversion
  initial begin
    sample_o = '0;
    sample_valid_o = 1'b0;
    ambient_temp_o = '0;
  end
  // one conversion; data are scrambled once the strobe drops
  task automatic send(input int s, input int t);
    @(posedge clock_i);
    sample_o       <= SAMPLE_W'(s);
    ambient_temp_o <= 9'(t);
    sample_valid_o <= 1'b1;
    @(posedge clock_i);
    sample_o       <= ~SAMPLE_W'(s); // stale data never looks valid
    ambient_temp_o <= ~9'(t);
    sample_valid_o <= 1'b0;
  endtask
endmodule
`default_nettype wire
